// ===== rtl/tpw_bank.sv
// threshold, identity and write-protect register bank with cutoff logic
`timescale 1ns/10ps
`default_nettype none
module tpw_bank
  import tpw_pkg::*;
#(
  parameter logic [15:0] DEVICE_IDENTIFIER = 16'h5a3c, // arbitrary value
  parameter logic [7:0] REVISION = 8'h01, // arbitrary value
  parameter int MEAS_W = 16
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic legacy_layout,
  input wire logic acc_valid,
  output logic acc_ready,
  input wire logic acc_write,
  input wire logic acc_a2,
  input wire logic [7:0] acc_table,
  input wire logic [7:0] acc_addr,
  input wire logic [7:0] acc_wdata,
  output logic acc_ack,
  output logic [7:0] acc_rdata,
  output logic acc_hit,
  output logic acc_wr_ok,
  input wire logic pw1_granted,
  input wire logic [MEAS_W-1:0] tx_power_meas,
  input wire logic [MEAS_W-1:0] rx_power_meas,
  input wire logic high_bias_alarm,
  output logic tx_high_trip,
  output logic tx_low_trip,
  output logic rx_signal_lost,
  output logic laser_cutoff_output,
  output logic [7:0] level1_read_protect_enables,
  output logic [31:0] first_level_password
);
  tpw_state_e state_reg;
  logic [3:0] ld_idx_reg;
  logic [7:0] work_reg [NV_SLOTS];
  logic [7:0] nv_rdata;
  logic nv_we;
  logic [3:0] nv_raddr;
  logic take;
  logic in_slot;
  logic [3:0] slot;
  logic guarded;
  logic wr_ok;
  logic store;
  logic [7:0] rd_byte;
  logic shut;
  logic [7:0] level1_write_protect_enables;
  logic [7:0] control_byte;
  logic [7:0] tx_power_upper_limit;
  logic [7:0] tx_power_lower_limit;
  logic [7:0] rx_signal_loss_limit;

  assign level1_write_protect_enables = work_reg[SLOT_WPE];
  assign control_byte = work_reg[SLOT_CTRL];
  assign tx_power_upper_limit = work_reg[SLOT_HTX];
  assign tx_power_lower_limit = work_reg[SLOT_LTX];
  assign rx_signal_loss_limit = work_reg[SLOT_LOS];

  // write-protect decode over the whole memory space of both slave addresses
  function automatic logic wr_guarded(input logic a2, input logic [7:0] tbl,
                                      input logic [7:0] addr, input logic legacy,
                                      input logic [7:0] wpe);
    logic [7:0] cfg_t;
    logic [7:0] usr_t;
    logic p;
    cfg_t = legacy ? TBL_CFG_LEG : TBL_CFG;
    usr_t = legacy ? TBL_USR_LEG : TBL_USR;
    p = 1'b0;
    if (!a2) begin
      p = (addr >= UPPER_BASE) ? wpe[WP_AUXUP] : wpe[WP_AUXLO];
    end else if (addr < UPPER_BASE) begin
      p = (addr <= LOWER_HI) && wpe[WP_LOWER];
    end else if (tbl == TBL_DEV) begin
      if (addr >= DEVPW_LO && addr <= DEVPW_HI) begin
        p = wpe[WP_DEVPW];
      end else if (addr >= MASK_LO) begin
        p = wpe[WP_MASK];
      end
    end else if ((tbl == cfg_t || tbl == TBL_EXT_A || tbl == TBL_EXT_B) && addr <= CFG_HI) begin
      p = wpe[WP_CFG];
    end else if (tbl == usr_t) begin
      p = (addr >= USRHI_LO) ? wpe[WP_USRHI] : wpe[WP_USRLO];
    end
    return p;
  endfunction : wr_guarded

  // power-up copy of the shadowed bytes; access held off until it ends
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_reg <= TPW_LD_REQ;
      ld_idx_reg <= 4'h0;
    end else begin
      case (state_reg)
        TPW_LD_REQ: begin
          state_reg <= TPW_LD_TAKE;
        end
        TPW_LD_TAKE: begin
          if (ld_idx_reg == SLOT_LAST) begin
            state_reg <= TPW_RUN;
          end else begin
            ld_idx_reg <= ld_idx_reg + 4'h1;
            state_reg <= TPW_LD_REQ;
          end
        end
        TPW_RUN: begin
          state_reg <= TPW_RUN;
        end
        default: begin
          state_reg <= TPW_LD_REQ;
        end
      endcase
    end
  end

  assign acc_ready = (state_reg == TPW_RUN);
  assign take = acc_valid && acc_ready;
  assign nv_raddr = ld_idx_reg;

  // which shadowed slot, if any, the access addresses
  always_comb begin
    in_slot = 1'b0;
    slot = SLOT_WPE;
    if (acc_a2 && acc_addr >= UPPER_BASE) begin
      if (acc_table == TBL_DEV) begin
        if (acc_addr >= OFS_WPE && acc_addr <= DEVPW_HI) begin
          in_slot = 1'b1;
          slot = 4'(acc_addr - OFS_WPE);
        end
      end else if (acc_table == (legacy_layout ? TBL_CFG_LEG : TBL_CFG)) begin
        if (acc_addr >= OFS_CTRL && acc_addr <= OFS_LOS) begin
          in_slot = 1'b1;
          slot = 4'(acc_addr - OFS_CTRL + 8'(SLOT_CTRL));
        end
      end
    end
  end

  assign guarded = wr_guarded(acc_a2, acc_table, acc_addr, legacy_layout,
                              level1_write_protect_enables);
  assign wr_ok = take && acc_write && (!guarded || pw1_granted);
  // refused writes fall through here and touch nothing
  assign store = wr_ok && in_slot;
  assign nv_we = store;

  tpw_nvm #(
    .WIDTH(8),
    .DEPTH(NV_DEPTH),
    .AW(4),
    .INIT(NV_FACTORY)
  ) u_nvm (
    .core_clk(core_clk),
    .we(nv_we),
    .waddr(slot),
    .wdata(acc_wdata),
    .raddr(nv_raddr),
    .rdata(nv_rdata)
  );

  // working copies: factory values in reset, then nvm image, then host writes
  always_ff @(posedge core_clk) begin
    if (rst) begin
      work_reg[SLOT_WPE] <= RST_WPE;
      work_reg[SLOT_RPE] <= RST_RPE;
      work_reg[SLOT_PW] <= RST_PW[31:24];
      work_reg[SLOT_PW+4'h1] <= RST_PW[23:16];
      work_reg[SLOT_PW+4'h2] <= RST_PW[15:8];
      work_reg[SLOT_PW+4'h3] <= RST_PW[7:0];
      work_reg[SLOT_CTRL] <= RST_CTRL;
      work_reg[SLOT_HTX] <= RST_HTX;
      work_reg[SLOT_LTX] <= RST_LTX;
      work_reg[SLOT_LOS] <= RST_LOS;
    end else if (state_reg == TPW_LD_TAKE) begin
      work_reg[ld_idx_reg] <= nv_rdata;
    end else if (store) begin
      work_reg[slot] <= acc_wdata;
    end
  end

  // read mux; identity bytes are constants so writes cannot reach them
  always_comb begin
    rd_byte = 8'h00;
    if (in_slot) begin
      rd_byte = work_reg[slot];
    end else if (acc_a2 && acc_table == TBL_DEV) begin
      if (acc_addr == OFS_ID_HI) begin
        rd_byte = DEVICE_IDENTIFIER[15:8];
      end else if (acc_addr == OFS_ID_LO) begin
        rd_byte = DEVICE_IDENTIFIER[7:0];
      end else if (acc_addr == OFS_REV) begin
        rd_byte = REVISION;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      acc_ack <= 1'b0;
      acc_rdata <= 8'h00;
      acc_hit <= 1'b0;
      acc_wr_ok <= 1'b0;
    end else begin
      acc_ack <= take;
      acc_wr_ok <= wr_ok;
      if (take) begin
        acc_rdata <= acc_write ? 8'h00 : rd_byte;
        acc_hit <= in_slot || (acc_a2 && acc_table == TBL_DEV &&
                   acc_addr >= OFS_ID_HI && acc_addr <= OFS_REV);
      end
    end
  end

  assign level1_read_protect_enables = work_reg[SLOT_RPE];
  assign first_level_password = {work_reg[SLOT_PW], work_reg[SLOT_PW+4'h1],
                                 work_reg[SLOT_PW+4'h2], work_reg[SLOT_PW+4'h3]};

  // trips stay low until the real thresholds are loaded
  tpw_trip #(.MEAS_W(MEAS_W), .THR_W(8), .ABOVE(1'b1)) u_htx (
    .core_clk(core_clk),
    .rst(rst),
    .enable(acc_ready),
    .meas(tx_power_meas),
    .limit(tx_power_upper_limit),
    .trip(tx_high_trip)
  );

  tpw_trip #(.MEAS_W(MEAS_W), .THR_W(8), .ABOVE(1'b0)) u_ltx (
    .core_clk(core_clk),
    .rst(rst),
    .enable(acc_ready),
    .meas(tx_power_meas),
    .limit(tx_power_lower_limit),
    .trip(tx_low_trip)
  );

  tpw_trip #(.MEAS_W(MEAS_W), .THR_W(8), .ABOVE(1'b0)) u_los (
    .core_clk(core_clk),
    .rst(rst),
    .enable(acc_ready),
    .meas(rx_power_meas),
    .limit(rx_signal_loss_limit),
    .trip(rx_signal_lost)
  );

  assign shut = (tx_high_trip && control_byte[CT_EN_HTX]) ||
                (high_bias_alarm && control_byte[CT_EN_HIGH_BIAS_ALARM]) ||
                (tx_low_trip && control_byte[CT_EN_LTX]);

  // polarity 0 is the reset value, so the pin idles high from reset
  always_ff @(posedge core_clk) begin
    if (rst) begin
      laser_cutoff_output <= 1'b1;
    end else begin
      laser_cutoff_output <= control_byte[CT_POL] ? shut : !shut;
    end
  end

  property p_id_read;
    @(posedge core_clk) disable iff (rst)
    take && !acc_write && acc_a2 && acc_table == TBL_DEV && acc_addr == OFS_ID_HI
    |=> acc_ack && acc_rdata == DEVICE_IDENTIFIER[15:8];
  endproperty
  a_id_read: assert property (p_id_read)
    else $error("identity high byte read wrong");

  property p_rev_read;
    @(posedge core_clk) disable iff (rst)
    take && !acc_write && acc_a2 && acc_table == TBL_DEV && acc_addr == OFS_REV
    |=> acc_rdata == REVISION && acc_hit;
  endproperty
  a_rev_read: assert property (p_rev_read)
    else $error("revision byte read wrong");

  property p_htx_trip;
    @(posedge core_clk) disable iff (rst)
    acc_ready && tx_power_meas[MEAS_W-1 -: 8] > tx_power_upper_limit |=> tx_high_trip;
  endproperty
  a_htx_trip: assert property (p_htx_trip)
    else $error("high tx power trip missed");

  property p_ltx_trip;
    @(posedge core_clk) disable iff (rst)
    acc_ready && tx_power_meas[MEAS_W-1 -: 8] >= tx_power_lower_limit |=> !tx_low_trip;
  endproperty
  a_ltx_trip: assert property (p_ltx_trip)
    else $error("low tx power trip false");

  property p_los_trip;
    @(posedge core_clk) disable iff (rst)
    acc_ready && rx_power_meas[MEAS_W-1 -: 8] < rx_signal_loss_limit |=> rx_signal_lost;
  endproperty
  a_los_trip: assert property (p_los_trip)
    else $error("signal loss trip missed");

  property p_guard_keeps;
    @(posedge core_clk) disable iff (rst)
    take && acc_write && in_slot && guarded && !pw1_granted
    |=> work_reg[$past(slot)] == $past(work_reg[slot]) && acc_ack && !acc_wr_ok;
  endproperty
  a_guard_keeps: assert property (p_guard_keeps)
    else $error("guarded write changed a register");

  property p_aux_lo_guard;
    @(posedge core_clk) disable iff (rst)
    take && acc_write && !acc_a2 && acc_addr < UPPER_BASE &&
    level1_write_protect_enables[WP_AUXLO] && !pw1_granted |=> !acc_wr_ok;
  endproperty
  a_aux_lo_guard: assert property (p_aux_lo_guard)
    else $error("aux low write passed while guarded");

  property p_write_both;
    @(posedge core_clk) disable iff (rst)
    take && acc_write && in_slot && !guarded
    |-> nv_we ##1 work_reg[$past(slot)] == $past(acc_wdata);
  endproperty
  a_write_both: assert property (p_write_both)
    else $error("open write did not reach both copies");

  property p_load_hold;
    @(posedge core_clk)
    rst ##1 !rst |-> !acc_ready [*8];
  endproperty
  a_load_hold: assert property (p_load_hold)
    else $error("access opened before load finished");

  property p_cutoff;
    @(posedge core_clk) disable iff (rst)
    tx_high_trip && control_byte[CT_EN_HTX] ##1 $stable(control_byte)
    |-> laser_cutoff_output == control_byte[CT_POL];
  endproperty
  a_cutoff: assert property (p_cutoff)
    else $error("cutoff level wrong on high power trip");
endmodule : tpw_bank
`default_nettype wire

// ===== rtl/tpw_pkg.sv
// constants for the threshold, identity and write-protect register bank
package tpw_pkg;
  localparam logic [7:0] TBL_CFG = 8'h04;
  localparam logic [7:0] TBL_CFG_LEG = 8'h01;
  localparam logic [7:0] TBL_USR = 8'h01;
  localparam logic [7:0] TBL_USR_LEG = 8'h00;
  localparam logic [7:0] TBL_DEV = 8'h05;
  localparam logic [7:0] TBL_EXT_A = 8'h02;
  localparam logic [7:0] TBL_EXT_B = 8'h03;
  localparam logic [7:0] OFS_ID_HI = 8'hc0;
  localparam logic [7:0] OFS_ID_LO = 8'hc1;
  localparam logic [7:0] OFS_REV = 8'hc2;
  localparam logic [7:0] OFS_WPE = 8'hd1;
  localparam logic [7:0] OFS_RPE = 8'hd2;
  localparam logic [7:0] OFS_PW = 8'hd3;
  localparam logic [7:0] OFS_CTRL = 8'hda;
  localparam logic [7:0] OFS_HTX = 8'hdb;
  localparam logic [7:0] OFS_LTX = 8'hdc;
  localparam logic [7:0] OFS_LOS = 8'hdd;
  localparam logic [7:0] UPPER_BASE = 8'h80;
  localparam logic [7:0] LOWER_HI = 8'h7a;
  localparam logic [7:0] DEVPW_LO = 8'hd0;
  localparam logic [7:0] DEVPW_HI = 8'hd6;
  localparam logic [7:0] MASK_LO = 8'hf8;
  localparam logic [7:0] CFG_HI = 8'hc7;
  localparam logic [7:0] USRHI_LO = 8'hf8;
  localparam int WP_DEVPW = 7;
  localparam int WP_MASK = 6;
  localparam int WP_CFG = 5;
  localparam int WP_USRHI = 4;
  localparam int WP_USRLO = 3;
  localparam int WP_LOWER = 2;
  localparam int WP_AUXUP = 1;
  localparam int WP_AUXLO = 0;
  localparam int CT_POL = 7;
  localparam int CT_EN_HTX = 6;
  localparam int CT_EN_HIGH_BIAS_ALARM = 5;
  localparam int CT_EN_LTX = 4;
  localparam logic [3:0] SLOT_WPE = 4'h0;
  localparam logic [3:0] SLOT_RPE = 4'h1;
  localparam logic [3:0] SLOT_PW = 4'h2;
  localparam logic [3:0] SLOT_CTRL = 4'h6;
  localparam logic [3:0] SLOT_HTX = 4'h7;
  localparam logic [3:0] SLOT_LTX = 4'h8;
  localparam logic [3:0] SLOT_LOS = 4'h9;
  localparam int NV_SLOTS = 10;
  localparam int NV_DEPTH = 16;
  localparam logic [3:0] SLOT_LAST = 4'h9;
  localparam logic [7:0] RST_WPE = 8'h00;
  localparam logic [7:0] RST_RPE = 8'h00;
  localparam logic [31:0] RST_PW = 32'h0000_0000;
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] RST_HTX = 8'hff;
  localparam logic [7:0] RST_LTX = 8'h00;
  localparam logic [7:0] RST_LOS = 8'h00;
  localparam logic [NV_DEPTH*8-1:0] NV_FACTORY = {48'h0, RST_LOS, RST_LTX, RST_HTX, RST_CTRL,
                                                  RST_PW[7:0], RST_PW[15:8], RST_PW[23:16], RST_PW[31:24],
                                                  RST_RPE, RST_WPE};
  typedef enum {TPW_LD_REQ, TPW_LD_TAKE, TPW_RUN} tpw_state_e;
endpackage : tpw_pkg

// ===== rtl/tpw_nvm.sv
// nonvolatile byte store behind the shadowed registers
`timescale 1ns/10ps
`default_nettype none
module tpw_nvm #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16,
  parameter int AW = 4,
  parameter logic [DEPTH*WIDTH-1:0] INIT = '0
) (
  input wire logic core_clk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [WIDTH-1:0] rdata
);
  logic [WIDTH-1:0] mem [DEPTH];

  // contents as programmed at manufacture; survives rst by design
  initial begin
    for (int i = 0; i < DEPTH; i++) begin
      mem[i] = INIT[i*WIDTH +: WIDTH];
    end
  end

  always_ff @(posedge core_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge core_clk) begin
    rdata <= mem[raddr];
  end
endmodule : tpw_nvm
`default_nettype wire

// ===== rtl/tpw_trip.sv
// fast-trip comparator on the top byte of a measurement
`timescale 1ns/10ps
`default_nettype none
module tpw_trip #(
  parameter int MEAS_W = 16,
  parameter int THR_W = 8,
  parameter bit ABOVE = 1'b1
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic [MEAS_W-1:0] meas,
  input wire logic [THR_W-1:0] limit,
  output logic trip
);
  logic [THR_W-1:0] meas_top;

  assign meas_top = meas[MEAS_W-1 -: THR_W];

  always_ff @(posedge core_clk) begin
    if (rst || !enable) begin
      trip <= 1'b0;
    end else begin
      trip <= ABOVE ? (meas_top > limit) : (meas_top < limit);
    end
  end
endmodule : tpw_trip
`default_nettype wire

// ===== verification/tpw_host.sv
// behavioural byte-access host driving the bank's register port
`timescale 1ns/10ps
`default_nettype none
module tpw_host (
  input wire logic core_clk,
  input wire logic acc_ready,
  output logic acc_valid,
  output logic acc_write,
  output logic acc_a2,
  output logic [7:0] acc_table,
  output logic [7:0] acc_addr,
  output logic [7:0] acc_wdata,
  input wire logic acc_ack,
  input wire logic [7:0] acc_rdata,
  input wire logic acc_hit,
  input wire logic acc_wr_ok
);
  initial begin
    acc_valid = 1'b0;
    acc_write = 1'b0;
    acc_a2 = 1'b0;
    acc_table = 8'h00;
    acc_addr = 8'h00;
    acc_wdata = 8'h00;
  end

  // resp = {ack, hit, wr_ok, rdata}; gap idles first to model a slow host
  task automatic xfer(input logic wr, input logic a2, input logic [7:0] tbl, input logic [7:0] addr,
                      input logic [7:0] wd, input int gap, output logic [10:0] resp);
    int n;
    repeat (gap + 1) @(posedge core_clk);
    acc_valid <= 1'b1;
    acc_write <= wr;
    acc_a2 <= a2;
    acc_table <= tbl;
    acc_addr <= addr;
    acc_wdata <= wd;
    n = 0;
    // ready is read once settled, never in the edge's own time step
    #1;
    while (acc_ready !== 1'b1 && n < 100) begin
      n++;
      @(posedge core_clk);
      #1;
    end
    // the next edge takes the request; release there, answer stands one cycle
    @(posedge core_clk);
    // released qualifiers are scrambled so stale values never look like a request
    acc_valid <= 1'b0;
    acc_write <= ~wr;
    acc_a2 <= ~a2;
    acc_table <= ~tbl;
    acc_addr <= ~addr;
    acc_wdata <= ~wd;
    #1;
    resp = {acc_ack, acc_hit, acc_wr_ok, acc_rdata};
  endtask : xfer
endmodule : tpw_host
`default_nettype wire

// ===== verification/tpw_bank_tb_top.sv
// self-checking bench for the threshold and write-protect bank
`timescale 1ns/10ps
`default_nettype none
module tpw_bank_tb_top;
  import tpw_pkg::*;
  localparam logic [15:0] ID = 16'h3c96; // arbitrary value
  localparam logic [7:0] REV = 8'h07; // arbitrary value
  logic core_clk, rst, legacy_layout, pw1_granted, high_bias_alarm;
  logic [15:0] tx_power_meas, rx_power_meas;
  logic acc_valid, acc_ready, acc_write, acc_a2, acc_ack, acc_hit, acc_wr_ok;
  logic [7:0] acc_table, acc_addr, acc_wdata, acc_rdata, level1_read_protect_enables;
  logic tx_high_trip, tx_low_trip, rx_signal_lost, laser_cutoff_output;
  logic [31:0] first_level_password;
  logic [10:0] r;
  int errors, compares, cycles, pace;

  tpw_bank #(.DEVICE_IDENTIFIER(ID), .REVISION(REV), .MEAS_W(16)) u_tpw_bank (.core_clk, .rst, .legacy_layout,
    .acc_valid, .acc_ready, .acc_write, .acc_a2, .acc_table, .acc_addr, .acc_wdata, .acc_ack, .acc_rdata,
    .acc_hit, .acc_wr_ok, .pw1_granted, .tx_power_meas, .rx_power_meas, .high_bias_alarm, .tx_high_trip,
    .tx_low_trip, .rx_signal_lost, .laser_cutoff_output, .level1_read_protect_enables, .first_level_password);
  tpw_host u_tpw_host (.core_clk, .acc_ready, .acc_valid, .acc_write, .acc_a2, .acc_table, .acc_addr,
    .acc_wdata, .acc_ack, .acc_rdata, .acc_hit, .acc_wr_ok);

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk
  task automatic chk8(input string n, input logic [7:0] seen, input logic [7:0] exp);
    chk(n, {24'h0, seen}, {24'h0, exp});
  endtask : chk8
  task automatic chk1(input string n, input logic seen, input logic exp);
    chk(n, {31'h0, seen}, {31'h0, exp});
  endtask : chk1

  task automatic final_report;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : final_report

  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      final_report();
    end
  end

  task automatic rchk(input string n, input logic a2, input logic [7:0] tbl, input logic [7:0] addr,
                      input logic [7:0] exp);
    u_tpw_host.xfer(1'b0, a2, tbl, addr, 8'h00, pace, r);
    chk1({n, " ack"}, r[10], 1'b1);
    chk8(n, r[7:0], exp);
  endtask : rchk
  task automatic wchk(input string n, input logic a2, input logic [7:0] tbl, input logic [7:0] addr,
                      input logic [7:0] wd, input logic ok);
    u_tpw_host.xfer(1'b1, a2, tbl, addr, wd, pace, r);
    chk1({n, " ack"}, r[10], 1'b1);
    chk1(n, r[8], ok);
  endtask : wchk
  task automatic set_wpe(input logic [7:0] v);
    @(posedge core_clk);
    pw1_granted <= 1'b1;
    wchk("enable write", 1'b1, 8'h05, 8'hd1, v, 1'b1);
    @(posedge core_clk);
    pw1_granted <= 1'b0;
  endtask : set_wpe

  task automatic do_reset;
    int n;
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    #1;
    chk1("ready while loading", acc_ready, 1'b0);
    n = 0;
    while (acc_ready !== 1'b1 && n < 40) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    chk1("ready after load", acc_ready, 1'b1);
  endtask : do_reset

  task automatic meas(input logic [15:0] tx, input logic [15:0] rx, input logic hb, input logic [3:0] e);
    @(posedge core_clk);
    tx_power_meas <= tx;
    rx_power_meas <= rx;
    high_bias_alarm <= hb;
    repeat (3) @(posedge core_clk);
    #1;
    chk1("high trip", tx_high_trip, e[3]);
    chk1("low trip", tx_low_trip, e[2]);
    chk1("signal loss", rx_signal_lost, e[1]);
    chk1("cutoff", laser_cutoff_output, e[0]);
  endtask : meas

  task automatic t_defaults;
    rchk("upper limit", 1'b1, TBL_CFG, 8'hdb, 8'hff);
    chk1("limit hit", r[9], 1'b1);
    rchk("lower limit", 1'b1, TBL_CFG, 8'hdc, 8'h00);
    rchk("loss limit", 1'b1, TBL_CFG, 8'hdd, 8'h00);
    rchk("write enables", 1'b1, 8'h05, 8'hd1, 8'h00);
    rchk("read enables", 1'b1, 8'h05, 8'hd2, 8'h00);
    for (int i = 0; i < 4; i++) begin
      rchk("password byte", 1'b1, 8'h05, 8'hd3 + 8'(i), 8'h00);
    end
    chk8("read enable port", level1_read_protect_enables, 8'h00);
    chk("password port", first_level_password, 32'h0);
    $display("test defaults done");
  endtask : t_defaults

  task automatic t_identity;
    rchk("id high", 1'b1, 8'h05, 8'hc0, ID[15:8]);
    chk1("id hit", r[9], 1'b1);
    rchk("id low", 1'b1, 8'h05, 8'hc1, ID[7:0]);
    rchk("revision", 1'b1, 8'h05, 8'hc2, REV);
    u_tpw_host.xfer(1'b1, 1'b1, 8'h05, 8'hc0, ~ID[15:8], 0, r);
    u_tpw_host.xfer(1'b1, 1'b1, 8'h05, 8'hc2, ~REV, 0, r);
    rchk("id high kept", 1'b1, 8'h05, 8'hc0, ID[15:8]);
    rchk("revision kept", 1'b1, 8'h05, 8'hc2, REV);
    rchk("unmapped", 1'b1, 8'h05, 8'hc5, 8'h00);
    chk1("unmapped hit", r[9], 1'b0);
    $display("test identity done");
  endtask : t_identity

  task automatic t_limits;
    wchk("upper write", 1'b1, TBL_CFG, 8'hdb, 8'h40, 1'b1);
    wchk("lower write", 1'b1, TBL_CFG, 8'hdc, 8'h20, 1'b1);
    wchk("loss write", 1'b1, TBL_CFG, 8'hdd, 8'h30, 1'b1);
    rchk("upper limit", 1'b1, TBL_CFG, 8'hdb, 8'h40);
    wchk("control", 1'b1, TBL_CFG, 8'hda, 8'hc0, 1'b1);
    meas(16'h40ff, 16'h3000, 1'b0, 4'b0000);
    meas(16'h4100, 16'h3000, 1'b0, 4'b1001);
    meas(16'h1fff, 16'h2fff, 1'b0, 4'b0110);
    wchk("control", 1'b1, TBL_CFG, 8'hda, 8'h10, 1'b1);
    meas(16'h1fff, 16'h3000, 1'b0, 4'b0100);
    meas(16'h2000, 16'h3000, 1'b0, 4'b0001);
    wchk("control", 1'b1, TBL_CFG, 8'hda, 8'h20, 1'b1);
    meas(16'h2000, 16'h3000, 1'b1, 4'b0000);
    wchk("control", 1'b1, TBL_CFG, 8'hda, 8'h80, 1'b1);
    meas(16'hffff, 16'h0000, 1'b1, 4'b1010);
    @(posedge core_clk);
    legacy_layout <= 1'b1;
    wchk("legacy upper", 1'b1, 8'h01, 8'hdb, 8'h55, 1'b1);
    @(posedge core_clk);
    legacy_layout <= 1'b0;
    rchk("upper limit", 1'b1, TBL_CFG, 8'hdb, 8'h55);
    $display("test limits done");
  endtask : t_limits

  task automatic t_protect;
    logic [7:0] en;
    logic a2s [8] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
    logic [7:0] tbs [8] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h04, 8'h05, 8'h05};
    logic [7:0] ads [8] = '{8'h7f, 8'h80, 8'h7a, 8'hf7, 8'hf8, 8'hc7, 8'hf8, 8'hd6};
    for (int b = 0; b < 8; b++) begin
      pace = b % 3;
      for (int k = 0; k < 2; k++) begin
        en = (k == 1) ? (8'h01 << b) : ~(8'h01 << b);
        set_wpe(en);
        wchk("guarded write", a2s[b], tbs[b], ads[b], 8'h5a, ~en[b]);
      end
    end
    pace = 0;
    set_wpe(8'hff);
    wchk("lower 7b open", 1'b1, 8'h00, 8'h7b, 8'h11, 1'b1);
    set_wpe(8'h80);
    wchk("refused enables", 1'b1, 8'h05, 8'hd2, 8'hff, 1'b0);
    rchk("read enables kept", 1'b1, 8'h05, 8'hd2, 8'h00);
    chk("password port", first_level_password, 32'h0000_005a);
    @(posedge core_clk);
    pw1_granted <= 1'b1;
    wchk("granted enables", 1'b1, 8'h05, 8'hd2, 8'h3c, 1'b1);
    wchk("password msb", 1'b1, 8'h05, 8'hd3, 8'ha1, 1'b1);
    chk8("read enable port", level1_read_protect_enables, 8'h3c);
    chk("password port", first_level_password, 32'ha100_005a);
    $display("test protect done");
  endtask : t_protect

  task automatic t_reload;
    do_reset();
    rchk("upper reloaded", 1'b1, TBL_CFG, 8'hdb, 8'h55);
    rchk("enables reloaded", 1'b1, 8'h05, 8'hd1, 8'h80);
    rchk("read enables reloaded", 1'b1, 8'h05, 8'hd2, 8'h3c);
    $display("test reload done");
  endtask : t_reload

  initial begin
    rst = 1'b1;
    legacy_layout = 1'b0;
    pw1_granted = 1'b0;
    high_bias_alarm = 1'b0;
    tx_power_meas = 16'h0000;
    rx_power_meas = 16'hffff;
    errors = 0;
    compares = 0;
    cycles = 0;
    pace = 0;
    do_reset();
    t_defaults();
    t_identity();
    t_limits();
    t_protect();
    t_reload();
    final_report();
  end
endmodule : tpw_bank_tb_top
`default_nettype wire
